// file: fsot_pkg.sv
// Purpose: shared constants and types for the field-synced output toggler
// Assumes: 8-bit register address, 28-bit register data
// Notes: offsets are register indices on the plain register port
package fsot_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 28;
   localparam int POS_W = 24;
   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_TRIGGER = 8'h50;
   localparam logic [7:0] ADDR_COUNTER_CFG = 8'h51;
   localparam logic [7:0] ADDR_PROTOCOL = 8'h52;
   localparam logic [7:0] ADDR_STATUS = 8'h53;
   localparam logic [7:0] ADDR_TOGGLE_BASE = 8'h54;
   localparam int TOGGLE_REGS = 3;
   localparam int OUTPUTS = 2;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int ACTION_LSB = 0;
   localparam int COUNT_MAX_LSB = 0;
   localparam int COUNT_DELAY_LSB = 4;
   localparam int PROTO_W = 2;
   localparam int LUT_LSB = 10;
   localparam int LUT_SEL_LSB = 14;
   localparam int FIELD_ONE_LSB = 0;
   localparam int FIELD_TWO_LSB = 4;
   localparam int START_LEVEL_BIT = 8;
   // ----------------------------------------------------------------
   // reset values and codes
   // ----------------------------------------------------------------
   localparam logic [27:0] RESET_WORD = 28'h0000000;
   localparam logic [3:0] PER_FIELD_INDEX = 4'h1;
   typedef enum logic [2:0] {
      FSOT_ACT_IDLE = 3'h0,
      FSOT_ACT_SINGLE = 3'h1,
      FSOT_ACT_REPEAT = 3'h2,
      FSOT_ACT_DELAYED = 3'h3,
      FSOT_ACT_FORCE_IDLE = 3'h7
   } fsot_action_t;
   typedef enum logic [1:0] {
      FSOT_PROTO_OFF = 2'h0,
      FSOT_PROTO_PER_FIELD = 2'h1,
      FSOT_PROTO_SCHEDULED = 2'h2,
      FSOT_PROTO_REPEATING = 2'h3
   } fsot_proto_t;
   typedef enum logic [3:0] {
      FSOT_ST_IDLE = 4'h1,
      FSOT_ST_SINGLE = 4'h2,
      FSOT_ST_REPEAT = 4'h4,
      FSOT_ST_DELAY = 4'h8
   } fsot_state_t;
endpackage

// file: fsot_primary_counter.sv
// Purpose: primary field counter, advanced once per vertical sync
// Assumes: field_start is a one-cycle pulse at each field boundary
// Notes: a command is only seen together with field_start
`timescale 1ns/100ps
module fsot_primary_counter
   import fsot_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic field_start,
   input wire logic [2:0] action,
   input wire logic [3:0] count_max,
   input wire logic [3:0] count_delay,
   output logic [3:0] count,
   output fsot_state_t state
);
   logic [3:0] delay_left;
   logic at_max;

   // a maximum of zero behaves as one so a pass always ends
   assign at_max = (count >= count_max);

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state <= FSOT_ST_IDLE;
         count <= 4'h0;
         delay_left <= 4'h0;
      end else if (field_start) begin
         case (action)
            FSOT_ACT_SINGLE, FSOT_ACT_REPEAT: begin
               state <= (action == FSOT_ACT_SINGLE) ? FSOT_ST_SINGLE : FSOT_ST_REPEAT;
               count <= 4'h1;
            end
            FSOT_ACT_DELAYED: begin
               state <= (count_delay == 4'h0) ? FSOT_ST_SINGLE : FSOT_ST_DELAY;
               count <= (count_delay == 4'h0) ? 4'h1 : 4'h0;
               delay_left <= count_delay;
            end
            FSOT_ACT_FORCE_IDLE: begin
               state <= FSOT_ST_IDLE;
               count <= 4'h0;
            end
            default: begin
               case (state)
                  FSOT_ST_SINGLE: begin
                     state <= at_max ? FSOT_ST_IDLE : FSOT_ST_SINGLE;
                     count <= at_max ? 4'h0 : count + 4'h1;
                  end
                  FSOT_ST_REPEAT: begin
                     count <= at_max ? 4'h1 : count + 4'h1;
                  end
                  FSOT_ST_DELAY: begin
                     delay_left <= delay_left - 4'h1;
                     if (delay_left == 4'h1) begin
                        state <= FSOT_ST_SINGLE;
                        count <= 4'h1;
                     end
                  end
                  default: begin
                     state <= FSOT_ST_IDLE;
                     count <= 4'h0;
                  end
               endcase
            end
         endcase
      end
   end
endmodule // fsot_primary_counter

// file: fsot_toggle_gen.sv
// Purpose: one general output with two programmed toggles per field
// Assumes: position is the clock count since the last field start
// Notes: protocol takes effect at the field start after it is written
`timescale 1ns/100ps
module fsot_toggle_gen
   import fsot_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic field_start,
   input wire logic [1:0] next_protocol,
   input wire logic [23:0] position,
   input wire logic [23:0] toggle_one_pos,
   input wire logic [23:0] toggle_two_pos,
   input wire logic [3:0] toggle_one_field,
   input wire logic [3:0] toggle_two_field,
   input wire logic start_level,
   input wire logic [3:0] count,
   output logic [1:0] protocol,
   output logic level
);
   logic [3:0] field_index;
   logic hit_one;
   logic hit_two;

   // per-field protocol always sits in field one; the others follow the counter
   assign field_index = (protocol == FSOT_PROTO_PER_FIELD) ? PER_FIELD_INDEX : count;
   assign hit_one = (protocol != FSOT_PROTO_OFF) && (field_index != 4'h0) &&
                    (toggle_one_field == field_index) && (position == toggle_one_pos);
   assign hit_two = (protocol != FSOT_PROTO_OFF) && (field_index != 4'h0) &&
                    (toggle_two_field == field_index) && (position == toggle_two_pos);

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         protocol <= FSOT_PROTO_OFF;
      end else if (field_start) begin
         protocol <= next_protocol;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         level <= 1'b0;
      end else if (field_start) begin
         // per-field restarts every field; counter modes keep their level so a pulse can span fields
         if (next_protocol == FSOT_PROTO_PER_FIELD || protocol == FSOT_PROTO_OFF) begin
            level <= start_level;
         end
      end else if (protocol == FSOT_PROTO_OFF) begin
         level <= start_level;
      end else begin
         level <= level ^ hit_one ^ hit_two;
      end
   end
endmodule // fsot_toggle_gen

// file: fsot_field_toggler.sv
// Purpose: two field-synced general outputs with pair logic table
// Assumes: vertical_sync and register strobes synchronous to mclk
// Notes: all settings except the toggle registers are sampled at the vertical sync boundary
//
// Notes on behaviour
// - protocol one starts its toggles in the field after the write
// - each output has at most two toggle positions per field
// - per-field toggles repeat every field until protocol returns to zero
// - protocol two follows the primary field counter
// - protocol three follows the repeating counter, pulses may span fields
// - delayed counter mode waits a programmed number of whole fields
// - one table for the output pair; each pin picks table or own signal
// - table truth value is four bits at protocol bits 13 to 10
// - protocol register also selects table behaviour and receiving pins
// - trigger self-clears each field; software spaces writes by one field
// - primary counter advances once per vertical sync
// - action codes: 0 idle, 1 single, 2 repeat, 3 delayed, 7 force idle
// - counter maximum and delay are four-bit settings
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
module fsot_field_toggler
   import fsot_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic vertical_sync,
   input wire logic [7:0] reg_addr,
   input wire logic [27:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [27:0] reg_rdata,
   output logic general_output_one,
   output logic general_output_two
);
   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic vsync_prev;
   logic field_start;
   logic [23:0] position;
   logic [2:0] trigger;
   logic [3:0] count_max;
   logic [3:0] count_delay;
   logic [15:0] output_sequence_protocol;
   logic [3:0] pair_logic_table;
   logic [1:0] lut_select;
   logic [27:0] toggle_regs [OUTPUTS*TOGGLE_REGS];
   logic [3:0] count;
   fsot_state_t state;
   logic [1:0] raw_level;
   logic [1:0] applied_proto [OUTPUTS];
   logic lut_result;
   logic [27:0] next_rdata;
   logic hit_toggle_reg;
   logic [7:0] toggle_index;

   // ----------------------------------------------------------------
   // field boundary and position within the field
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         vsync_prev <= 1'b0;
      end else begin
         vsync_prev <= vertical_sync;
      end
   end

   // a field begins on the rising edge of vertical sync
   assign field_start = vertical_sync & ~vsync_prev;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         position <= 24'h000000;
      end else if (field_start) begin
         position <= 24'h000000;
      end else if (position != 24'hFFFFFF) begin
         // saturate so an overlong field cannot alias onto early toggles
         position <= position + 24'h000001;
      end
   end

   // ----------------------------------------------------------------
   // trigger register
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         trigger <= FSOT_ACT_IDLE;
      end else if (reg_write && reg_addr == ADDR_TRIGGER) begin
         // a write in the boundary cycle wins and is kept for the next boundary
         trigger <= reg_wdata[ACTION_LSB +: 3];
      end else if (field_start) begin
         trigger <= FSOT_ACT_IDLE;
      end
   end

   // ----------------------------------------------------------------
   // counter configuration
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         count_max <= 4'h0;
         count_delay <= 4'h0;
      end else if (reg_write && reg_addr == ADDR_COUNTER_CFG) begin
         count_max <= reg_wdata[COUNT_MAX_LSB +: 4];
         count_delay <= reg_wdata[COUNT_DELAY_LSB +: 4];
      end
   end

   // the counter reads these only at a field start, so a setting written in a field
   // takes effect at the same boundary as a trigger written beside it

   // ----------------------------------------------------------------
   // protocol register
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         output_sequence_protocol <= 16'h0000;
      end else if (reg_write && reg_addr == ADDR_PROTOCOL) begin
         output_sequence_protocol <= reg_wdata[15:0];
      end
   end

   // table and pin selection also change only between fields
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pair_logic_table <= 4'h0;
         lut_select <= 2'h0;
      end else if (field_start) begin
         pair_logic_table <= output_sequence_protocol[LUT_LSB +: 4];
         lut_select <= output_sequence_protocol[LUT_SEL_LSB +: 2];
      end
   end

   // ----------------------------------------------------------------
   // toggle position and field setting registers
   // ----------------------------------------------------------------
   assign toggle_index = reg_addr - ADDR_TOGGLE_BASE;
   assign hit_toggle_reg = (reg_addr >= ADDR_TOGGLE_BASE) &&
                           (toggle_index < 8'(OUTPUTS * TOGGLE_REGS));

   generate
      for (genvar r = 0; r < OUTPUTS * TOGGLE_REGS; r++) begin : g_toggle_reg
         always_ff @(posedge mclk or negedge resetn) begin
            if (!resetn) begin
               toggle_regs[r] <= RESET_WORD;
            end else if (reg_write && hit_toggle_reg && toggle_index == 8'(r)) begin
               toggle_regs[r] <= reg_wdata;
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // primary field counter
   // ----------------------------------------------------------------
   fsot_primary_counter u_counter (
      .mclk(mclk),
      .resetn(resetn),
      .field_start(field_start),
      .action(trigger),
      .count_max(count_max),
      .count_delay(count_delay),
      .count(count),
      .state(state)
   );

   // ----------------------------------------------------------------
   // toggle generators, one per output
   // ----------------------------------------------------------------
   generate
      for (genvar g = 0; g < OUTPUTS; g++) begin : g_output
         fsot_toggle_gen u_toggle (
            .mclk(mclk),
            .resetn(resetn),
            .field_start(field_start),
            .next_protocol(output_sequence_protocol[g*PROTO_W +: PROTO_W]),
            .position(position),
            .toggle_one_pos(toggle_regs[g*TOGGLE_REGS][POS_W-1:0]),
            .toggle_two_pos(toggle_regs[g*TOGGLE_REGS+1][POS_W-1:0]),
            .toggle_one_field(toggle_regs[g*TOGGLE_REGS+2][FIELD_ONE_LSB +: 4]),
            .toggle_two_field(toggle_regs[g*TOGGLE_REGS+2][FIELD_TWO_LSB +: 4]),
            .start_level(toggle_regs[g*TOGGLE_REGS+2][START_LEVEL_BIT]),
            .count(count),
            .protocol(applied_proto[g]),
            .level(raw_level[g])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // pair logic table and output pins
   // ----------------------------------------------------------------
   // index bit 0 is output one, bit 1 output two, so any two-input function fits
   assign lut_result = pair_logic_table[{raw_level[1], raw_level[0]}];

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         general_output_one <= 1'b0;
      end else begin
         general_output_one <= lut_select[0] ? lut_result : raw_level[0];
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         general_output_two <= 1'b0;
      end else begin
         general_output_two <= lut_select[1] ? lut_result : raw_level[1];
      end
   end

   // ----------------------------------------------------------------
   // register read back
   // ----------------------------------------------------------------
   always_comb begin
      next_rdata = 28'h0000000;
      if (reg_addr == ADDR_TRIGGER) begin
         next_rdata[2:0] = trigger;
      end else if (reg_addr == ADDR_COUNTER_CFG) begin
         next_rdata[7:0] = {count_delay, count_max};
      end else if (reg_addr == ADDR_PROTOCOL) begin
         next_rdata[15:0] = output_sequence_protocol;
      end else if (reg_addr == ADDR_STATUS) begin
         // live state: counter value, state code, applied protocols, pin levels
         next_rdata[3:0] = count;
         next_rdata[7:4] = state;
         next_rdata[9:8] = applied_proto[0];
         next_rdata[11:10] = applied_proto[1];
         next_rdata[12] = general_output_one;
         next_rdata[13] = general_output_two;
      end else if (hit_toggle_reg) begin
         next_rdata = toggle_regs[toggle_index[2:0]];
      end
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 28'h0000000;
      end else if (reg_read) begin
         reg_rdata <= next_rdata;
      end else begin
         reg_rdata <= 28'h0000000;
      end
   end
endmodule // fsot_field_toggler

// file: fsot_field_toggler_props.sv
// Purpose: port checks for the field-synced output toggler
// Assumes: the bench writes in a field start cycle only once, its first counter setting write after reset
// Notes: helper logic shadows field starts and register writes
`timescale 1ns/100ps
module fsot_field_toggler_props
   import fsot_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic vertical_sync,
   input wire logic [7:0] reg_addr,
   input wire logic [27:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [27:0] reg_rdata,
   input wire logic general_output_one,
   input wire logic general_output_two
);
   logic vs_q, rd_q, fs_since, chg_q;
   logic [7:0] ra_q, sh_cfg;
   logic [15:0] sh_proto, app, app_q;
   logic [11:0] st_prev;
   logic [2:0] quiet;
   wire logic fs = vertical_sync & ~vs_q;
   wire logic st_rd = rd_q && (ra_q == ADDR_STATUS);
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         vs_q <= 1'b0;
         rd_q <= 1'b0;
         ra_q <= 8'h00;
         app <= 16'h0000;
         app_q <= 16'h0000;
         quiet <= 3'h0;
      end else begin
         vs_q <= vertical_sync;
         rd_q <= reg_read;
         ra_q <= reg_addr;
         app_q <= app;
         if (fs) app <= sh_proto;
         // pins may still move a few cycles after a field start or a write
         if (fs || reg_write) quiet <= 3'h0;
         else if (quiet != 3'h7) quiet <= quiet + 3'h1;
      end
   end
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sh_proto <= 16'h0000;
         sh_cfg <= 8'h00;
      end else if (reg_write) begin
         if (reg_addr == ADDR_PROTOCOL) sh_proto <= reg_wdata[15:0];
         if (reg_addr == ADDR_COUNTER_CFG) sh_cfg <= reg_wdata[7:0];
      end
   end
   // chg_q tells whether a field start fell between two status reads
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         fs_since <= 1'b0;
         chg_q <= 1'b1;
         st_prev <= 12'h000;
      end else begin
         if (reg_read && reg_addr == ADDR_STATUS) begin
            chg_q <= fs_since | fs;
            fs_since <= fs;
         end else begin
            fs_since <= fs_since | fs;
         end
         if (st_rd) st_prev <= reg_rdata[11:0];
      end
   end
   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   property p_rd_idle;
      @(posedge mclk) disable iff (!resetn) !rd_q |-> reg_rdata == 28'h0000000;
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data not zero outside a read answer");
   property p_proto_back;
      @(posedge mclk) disable iff (!resetn) rd_q && ra_q == ADDR_PROTOCOL |-> reg_rdata[15:0] == sh_proto;
   endproperty
   a_proto_back: assert property (p_proto_back)
      else $error("protocol register read back wrong");
   property p_cfg_back;
      @(posedge mclk) disable iff (!resetn) rd_q && ra_q == ADDR_COUNTER_CFG |-> reg_rdata[7:0] == sh_cfg;
   endproperty
   a_cfg_back: assert property (p_cfg_back)
      else $error("counter setting read back wrong");
   property p_applied;
      @(posedge mclk) disable iff (!resetn) st_rd |-> reg_rdata[11:8] == app_q[3:0];
   endproperty
   a_applied: assert property (p_applied)
      else $error("applied protocol moved outside a field start");
   property p_count_field;
      @(posedge mclk) disable iff (!resetn) st_rd && !chg_q |-> reg_rdata[11:0] == st_prev;
   endproperty
   a_count_field: assert property (p_count_field)
      else $error("counter moved without a field start");
   property p_state_onehot;
      @(posedge mclk) disable iff (!resetn) st_rd |-> $onehot(reg_rdata[7:4]);
   endproperty
   a_state_onehot: assert property (p_state_onehot)
      else $error("counter state not one-hot");
   property p_idle_zero;
      @(posedge mclk) disable iff (!resetn)
         st_rd && (reg_rdata[7:4] == 4'h1 || reg_rdata[7:4] == 4'h8) |-> reg_rdata[3:0] == 4'h0;
   endproperty
   a_idle_zero: assert property (p_idle_zero)
      else $error("count not zero while idle or delaying");
   property p_off_one;
      @(posedge mclk) disable iff (!resetn)
         quiet > 3'h3 && app[1:0] == 2'h0 && !app[14] |-> $stable(general_output_one);
   endproperty
   a_off_one: assert property (p_off_one)
      else $error("output one moved while its protocol is off");
   property p_off_two;
      @(posedge mclk) disable iff (!resetn)
         quiet > 3'h3 && app[3:2] == 2'h0 && !app[15] |-> $stable(general_output_two);
   endproperty
   a_off_two: assert property (p_off_two)
      else $error("output two moved while its protocol is off");
endmodule // fsot_field_toggler_props
bind fsot_field_toggler fsot_field_toggler_props fsot_field_toggler_props_inst (
   .mclk(mclk), .resetn(resetn), .vertical_sync(vertical_sync), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
   .general_output_one(general_output_one), .general_output_two(general_output_two));

// file: fsot_shutter_model.sv
// Purpose: far side: field sync source and shutter-side edge counter
// Assumes: fields of FIELD_LEN cycles with sync high for SYNC_W cycles
// Notes: edges_one holds the pin one edge count of the last field
`timescale 1ns/100ps
module fsot_shutter_model #(
   parameter int FIELD_LEN = 200,
   parameter int SYNC_W = 4
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic general_output_one,
   output logic vertical_sync,
   output logic [3:0] edges_one
);
   int tick = 0;
   logic vs_r = 1'b0;
   logic pin_q = 1'b0;
   logic [3:0] run = 4'h0;
   assign vertical_sync = vs_r;
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         tick <= 0;
         vs_r <= 1'b0;
         run <= 4'h0;
         edges_one <= 4'h0;
      end else begin
         tick <= (tick == FIELD_LEN - 1) ? 0 : tick + 1;
         vs_r <= (tick < SYNC_W);
         pin_q <= general_output_one;
         if (tick == 0) begin
            edges_one <= run;
            run <= {3'h0, pin_q != general_output_one};
         end else if (pin_q != general_output_one) begin
            run <= run + 4'h1;
         end
      end
   end
endmodule // fsot_shutter_model

// file: tb_top.sv
// Purpose: self-checking bench for the field-synced output toggler
// Assumes: 200-cycle fields from the shutter-side model
// Notes: pins are sampled well away from toggle positions
`timescale 1ns/100ps
module tb_top;
   import fsot_pkg::*;
   typedef struct packed {
      logic [7:0] a;
      logic [27:0] w;
      logic [27:0] r;
   } fsot_row_t;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic vertical_sync, general_output_one, general_output_two;
   logic [7:0] reg_addr = 8'h00;
   logic [27:0] reg_wdata = 28'h0000000;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [27:0] reg_rdata, d;
   logic [3:0] edges_one;
   logic vs_q = 1'b0;
   int pos = 0;
   int n_mismatch = 0;
   int compares = 0;
   fsot_row_t rows [10] = '{'{8'h51, 28'h00000A3, 28'h00000A3}, '{8'h54, 28'h0FFFFFF, 28'h0FFFFFF},
      '{8'h55, 28'h0000001, 28'h0000001}, '{8'h56, 28'h00000F1, 28'h00000F1},
      '{8'h57, 28'h0123456, 28'h0123456}, '{8'h58, 28'h0ABCDEF, 28'h0ABCDEF},
      '{8'h59, 28'h00000E2, 28'h00000E2}, '{8'h52, 28'h0003C00, 28'h0003C00},
      '{8'h60, 28'h0000055, 28'h0000000}, '{8'h53, 28'h0FFFFFF, 28'h0000010}};
   logic [3:0] luts [5] = '{4'h6, 4'h8, 4'hE, 4'h7, 4'h6};
   logic [1:0] sels [5] = '{2'h3, 2'h3, 2'h3, 2'h3, 2'h1};
   logic [7:0] cfgs [6] = '{8'h03, 8'h02, 8'h22, 8'h03, 8'h03, 8'h03};
   logic [7:0] ex [6][6] = '{'{8'h21, 8'h22, 8'h23, 8'h10, 8'h10, 8'h10},
      '{8'h41, 8'h42, 8'h41, 8'h42, 8'h41, 8'h42}, '{8'h80, 8'h80, 8'h21, 8'h22, 8'h10, 8'h10},
      '{6{8'h10}}, '{6{8'h10}}, '{6{8'h10}}};
   fsot_field_toggler fsot_field_toggler_inst (.mclk(mclk), .resetn(resetn), .vertical_sync(vertical_sync),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .general_output_one(general_output_one), .general_output_two(general_output_two));
   fsot_shutter_model #(.FIELD_LEN(200), .SYNC_W(4)) fsot_shutter_model_inst (.mclk(mclk), .resetn(resetn),
      .general_output_one(general_output_one), .vertical_sync(vertical_sync), .edges_one(edges_one));
   always #20 mclk = ~mclk;
   // pos mirrors the design's position count inside a field
   always @(posedge mclk) begin
      vs_q <= vertical_sync;
      pos <= (vertical_sync && !vs_q) ? 0 : pos + 1;
   end
   task automatic chk(input logic [27:0] seen, input logic [27:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [27:0] v);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_write <= 1'b1;
      @(posedge mclk);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge mclk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge mclk);
      reg_read <= 1'b0;
      @(negedge mclk);
      d = reg_rdata;
   endtask
   task automatic at(input int p);
      @(negedge mclk);
      while (pos != p) @(negedge mclk);
   endtask
   task automatic smp(input int p, input logic e1, input logic e2);
      at(p);
      chk({26'h0, general_output_two, general_output_one}, {26'h0, e2, e1});
   endtask
   task automatic summarize;
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      #2000000;
      n_mismatch++;
      summarize;
   end
   initial begin
      repeat (2) @(posedge mclk);
      resetn <= 1'b1;
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].w);
         rd(rows[i].a);
         chk(d, rows[i].r);
      end
      @(posedge mclk);
      resetn <= 1'b0;
      repeat (2) @(posedge mclk);
      resetn <= 1'b1;
      rd(ADDR_PROTOCOL);
      chk(d, 28'h0000000);
      rd(ADDR_STATUS);
      chk(d, 28'h0000010);
      wr(ADDR_TOGGLE_BASE, 28'h0000014);
      wr(8'h55, 28'h000003C);
      wr(8'h56, 28'h0000011);
      wr(8'h57, 28'h0000028);
      wr(8'h58, 28'h0000050);
      wr(8'h59, 28'h0000011);
      at(5);
      wr(ADDR_PROTOCOL, 28'h0000001);
      smp(40, 1'b0, 1'b0);
      for (int f = 0; f < 3; f++) begin
         smp(10, 1'b0, 1'b0);
         smp(40, 1'b1, 1'b0);
         smp(100, 1'b0, 1'b0);
      end
      at(10);
      chk({24'h0, edges_one}, 28'h0000002);
      at(120);
      wr(ADDR_PROTOCOL, 28'h0000000);
      smp(40, 1'b0, 1'b0);
      smp(40, 1'b0, 1'b0);
      for (int i = 0; i < 5; i++) begin
         at(120);
         wr(ADDR_PROTOCOL, {12'h000, sels[i], luts[i], 10'h005});
         smp(30, luts[i][1], sels[i][1] ? luts[i][1] : 1'b0);
         smp(50, luts[i][3], sels[i][1] ? luts[i][3] : 1'b1);
         smp(70, luts[i][2], sels[i][1] ? luts[i][2] : 1'b1);
         smp(100, luts[i][0], sels[i][1] ? luts[i][0] : 1'b0);
      end
      at(120);
      wr(ADDR_PROTOCOL, 28'h0000000);
      for (int a = 0; a < 6; a++) begin
         at(120);
         wr(ADDR_COUNTER_CFG, {20'h00000, cfgs[a]});
         wr(ADDR_TRIGGER, {25'h0000000, 3'(a + 1)});
         for (int f = 0; f < 6; f++) begin
            at(60);
            rd(ADDR_STATUS);
            chk({20'h00000, d[7:0]}, {20'h00000, ex[a][f]});
         end
         at(120);
         wr(ADDR_TRIGGER, 28'h0000007);
         at(60);
         rd(ADDR_STATUS);
         chk({20'h00000, d[7:0]}, 28'h0000010);
      end
      wr(8'h56, 28'h0000031);
      wr(ADDR_PROTOCOL, 28'h0000002);
      at(120);
      smp(100, 1'b0, 1'b0);
      at(120);
      wr(ADDR_TRIGGER, 28'h0000001);
      smp(10, 1'b0, 1'b0);
      smp(40, 1'b1, 1'b0);
      smp(100, 1'b1, 1'b0);
      smp(40, 1'b1, 1'b0);
      smp(100, 1'b1, 1'b0);
      smp(100, 1'b0, 1'b0);
      at(120);
      wr(ADDR_PROTOCOL, 28'h0000000);
      at(120);
      wr(8'h56, 28'h0000021);
      wr(ADDR_COUNTER_CFG, 28'h0000002);
      wr(ADDR_PROTOCOL, 28'h0000003);
      at(120);
      wr(ADDR_TRIGGER, 28'h0000002);
      for (int f = 0; f < 2; f++) begin
         smp(100, 1'b1, 1'b0);
         smp(10, 1'b1, 1'b0);
         smp(100, 1'b0, 1'b0);
      end
      summarize;
   end
endmodule // tb_top
